// ===== hw/hbmfc_defines.svh
`ifndef HBMFC_DEFINES_SVH
`define HBMFC_DEFINES_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define HBMFC_CLK_HZ 25000000
`define HBMFC_SLEEP_MS 10
`define HBMFC_SLEEP_CYC (`HBMFC_SLEEP_MS * `HBMFC_CLK_HZ / 1000)
`define HBMFC_CP_MS 11
`define HBMFC_CP_CYC (`HBMFC_CP_MS * `HBMFC_CLK_HZ / 1000)
`define HBMFC_DEG_US 1
`define HBMFC_DEG_CYC (`HBMFC_DEG_US * `HBMFC_CLK_HZ / 1000000)
`define HBMFC_RETRY_MS 1
`define HBMFC_RETRY_CYC (`HBMFC_RETRY_MS * `HBMFC_CLK_HZ / 1000)

// ****************************************************************
// register map
// ****************************************************************
`define HBMFC_ADDR_STATE 8'h00
`define HBMFC_ADDR_IRQ_STAT 8'h04
`define HBMFC_ADDR_IRQ_CLR 8'h08
`define HBMFC_ADDR_IRQ_EN 8'h0C
`define HBMFC_IRQ_W 6
`define HBMFC_IRQ_OC 0
`define HBMFC_IRQ_SHORT 1
`define HBMFC_IRQ_OT 2
`define HBMFC_IRQ_UV 3
`define HBMFC_IRQ_SLEEP 4
`define HBMFC_IRQ_WAKE 5
`define HBMFC_IRQ_EN_RST 6'h00
`define HBMFC_RESP_OKAY 2'h0
`define HBMFC_RESP_SLVERR 2'h2

`endif

// ===== hw/hbmfc_pkg.sv
package hbmfc_pkg;

    typedef enum logic [1:0] {MD_STANDBY, MD_REVERSE, MD_FORWARD, MD_BRAKE}
        hbmfc_mode_t;
    typedef enum logic [1:0] {PW_ACTIVE, PW_SLEEP, PW_WAKE} hbmfc_pwr_t;
    typedef enum logic {PR_RUN, PR_RETRY} hbmfc_prot_t;

    typedef struct packed {
        logic high_switch_a;
        logic low_switch_a;
        logic high_switch_b;
        logic low_switch_b;
    } hbmfc_sw_t;

    typedef struct packed {
        logic uv_low;
        logic uv_ok;
        logic oc;
        logic short_hit;
        logic ot_high;
        logic ot_rec;
    } hbmfc_flags_t;

endpackage

// ===== hw/hbmfc_top.sv
`include "hbmfc_defines.svh"

module hbmfc_top
    import hbmfc_pkg::*;
#(
    parameter int unsigned SLEEP_CYC = `HBMFC_SLEEP_CYC,
    parameter int unsigned CP_CYC = `HBMFC_CP_CYC,
    parameter int unsigned RETRY_CYC = `HBMFC_RETRY_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control inputs from host
    input wire logic input_a,
    input wire logic input_b,
    // analog comparator flags
    input wire hbmfc_flags_t flags,
    // bridge drive
    output hbmfc_sw_t sw,
    output logic out_a,
    output logic out_a_oe,
    output logic out_b,
    output logic out_b_oe,
    output logic irq,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam logic [19:0] SLEEP_LIM = 20'(SLEEP_CYC);
    localparam logic [19:0] CP_LIM = 20'(CP_CYC - 1);
    localparam logic [19:0] RETRY_LIM = 20'(RETRY_CYC - 1);
    localparam logic [19:0] DEG_LIM = 20'(`HBMFC_DEG_CYC);
    localparam int IW = `HBMFC_IRQ_W;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic in_a;
    logic in_b;
    hbmfc_flags_t fl;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end
        else
        begin
            sync1 <= {input_a, input_b, flags};
            sync2 <= sync1;
        end
    end

    assign in_a = sync2[7];
    assign in_b = sync2[6];
    assign fl = sync2[5:0];

    // ****************************************************************
    // mode, power, protection state
    // ****************************************************************
    hbmfc_mode_t mode;
    hbmfc_pwr_t pwr, next_pwr;
    hbmfc_prot_t prot, next_prot;
    logic [19:0] pcnt, next_pcnt;
    logic [19:0] dcnt, next_dcnt;
    logic [19:0] rcnt, next_rcnt;
    logic lockout, next_lockout;
    logic ot, next_ot;
    logic retry_short, next_retry_short;
    logic driving;
    logic enable;
    logic [IW-1:0] ev;
    hbmfc_sw_t next_sw;

    assign mode = hbmfc_mode_t'({in_a, in_b});

    always_comb
    begin
        next_pwr = pwr;
        next_pcnt = pcnt;
        next_prot = prot;
        next_dcnt = 20'h00000;
        next_rcnt = rcnt;
        next_lockout = lockout;
        next_ot = ot;
        next_retry_short = retry_short;
        ev = '0;
        driving = (mode != MD_STANDBY) && (pwr == PW_ACTIVE);
        case (pwr)
            PW_ACTIVE:
            begin
                if (mode == MD_STANDBY)
                begin
                    if (pcnt >= SLEEP_LIM)
                    begin
                        next_pwr = PW_SLEEP;
                        next_pcnt = 20'h00000;
                        ev[`HBMFC_IRQ_SLEEP] = 1'b1;
                    end
                    else
                    begin
                        next_pcnt = pcnt + 20'h00001;
                    end
                end
                else
                begin
                    next_pcnt = 20'h00000;
                end
            end
            PW_SLEEP:
            begin
                if (in_a || in_b)
                begin
                    next_pwr = PW_WAKE;
                    next_pcnt = 20'h00000;
                    ev[`HBMFC_IRQ_WAKE] = 1'b1;
                end
            end
            PW_WAKE:
            begin
                next_pcnt = pcnt + 20'h00001;
                if (pcnt >= CP_LIM)
                begin
                    next_pwr = PW_ACTIVE;
                    next_pcnt = 20'h00000;
                end
            end
            default:
            begin
                next_pwr = PW_ACTIVE;
                next_pcnt = 20'h00000;
            end
        endcase
        // supply lockout latch with hysteresis, frozen in sleep
        if (pwr != PW_SLEEP)
        begin
            if (fl.uv_low)
            begin
                next_lockout = 1'b1;
                ev[`HBMFC_IRQ_UV] = !lockout;
            end
            else if (fl.uv_ok)
            begin
                next_lockout = 1'b0;
            end
            if (fl.ot_high)
            begin
                next_ot = 1'b1;
                ev[`HBMFC_IRQ_OT] = !ot;
            end
            else if (fl.ot_rec)
            begin
                next_ot = 1'b0;
            end
        end
        case (prot)
            PR_RUN:
            begin
                // current guards only watch a driving bridge
                if (driving && !lockout && fl.short_hit)
                begin
                    next_prot = PR_RETRY;
                    next_rcnt = 20'h00000;
                    next_retry_short = 1'b1;
                    ev[`HBMFC_IRQ_SHORT] = 1'b1;
                end
                else if (driving && !lockout && fl.oc)
                begin
                    next_dcnt = dcnt + 20'h00001;
                    if (dcnt >= DEG_LIM)
                    begin
                        next_prot = PR_RETRY;
                        next_rcnt = 20'h00000;
                        next_dcnt = 20'h00000;
                        next_retry_short = 1'b0;
                        ev[`HBMFC_IRQ_OC] = 1'b1;
                    end
                end
            end
            PR_RETRY:
            begin
                next_rcnt = rcnt + 20'h00001;
                if (rcnt >= RETRY_LIM)
                begin
                    next_rcnt = 20'h00000;
                    if (!(retry_short && fl.short_hit))
                    begin
                        next_prot = PR_RUN;
                    end
                end
            end
            default:
            begin
                next_prot = PR_RUN;
            end
        endcase
        if (pwr == PW_SLEEP)
        begin
            next_prot = PR_RUN;
            next_rcnt = 20'h00000;
        end
        enable = (next_pwr == PW_ACTIVE) && !next_lockout && !next_ot &&
            (next_prot == PR_RUN);
        next_sw = '0;
        if (enable)
        begin
            case (mode)
                MD_FORWARD:
                begin
                    next_sw.high_switch_a = 1'b1;
                    next_sw.low_switch_b = 1'b1;
                end
                MD_REVERSE:
                begin
                    next_sw.low_switch_a = 1'b1;
                    next_sw.high_switch_b = 1'b1;
                end
                MD_BRAKE:
                begin
                    next_sw.low_switch_a = 1'b1;
                    next_sw.low_switch_b = 1'b1;
                end
                default:
                begin
                    next_sw = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pwr <= PW_ACTIVE;
            prot <= PR_RUN;
            pcnt <= 20'h00000;
            dcnt <= 20'h00000;
            rcnt <= 20'h00000;
            lockout <= 1'b1;
            ot <= 1'b0;
            retry_short <= 1'b0;
            sw <= '0;
            out_a <= 1'b0;
            out_a_oe <= 1'b0;
            out_b <= 1'b0;
            out_b_oe <= 1'b0;
        end
        else
        begin
            pwr <= next_pwr;
            prot <= next_prot;
            pcnt <= next_pcnt;
            dcnt <= next_dcnt;
            rcnt <= next_rcnt;
            lockout <= next_lockout;
            ot <= next_ot;
            retry_short <= next_retry_short;
            sw <= next_sw;
            out_a <= next_sw.high_switch_a;
            out_a_oe <= next_sw.high_switch_a | next_sw.low_switch_a;
            out_b <= next_sw.high_switch_b;
            out_b_oe <= next_sw.high_switch_b | next_sw.low_switch_b;
        end
    end

    // ****************************************************************
    // register slave and interrupt
    // ****************************************************************
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_strb0, next_w_strb0;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [IW-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en, clr;
    logic next_irq;

    always_comb
    begin
        next_aw_got = aw_got | (s_axi_awvalid & s_axi_awready);
        next_aw_addr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr :
            aw_addr;
        next_w_got = w_got | (s_axi_wvalid & s_axi_wready);
        next_w_data = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
        // strobe kept with the data, the master may drop it once taken
        next_w_strb0 = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] :
            w_strb0;
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        next_irq_en = irq_en;
        clr = '0;
        if (aw_got && w_got)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `HBMFC_RESP_OKAY;
            case (aw_addr)
                `HBMFC_ADDR_IRQ_CLR:
                begin
                    clr = w_strb0 ? w_data[IW-1:0] : '0;
                end
                `HBMFC_ADDR_IRQ_EN:
                begin
                    if (w_strb0)
                    begin
                        next_irq_en = w_data[IW-1:0];
                    end
                end
                `HBMFC_ADDR_STATE, `HBMFC_ADDR_IRQ_STAT:
                begin
                    next_bresp = `HBMFC_RESP_OKAY;
                end
                default:
                begin
                    next_bresp = `HBMFC_RESP_SLVERR;
                end
            endcase
        end
        next_awready = ~next_aw_got & ~next_bvalid & ~(aw_got & w_got);
        next_wready = ~next_w_got & ~next_bvalid & ~(aw_got & w_got);
        // set wins over clear
        next_irq_stat = (irq_stat & ~clr) | ev;
        next_irq = |(next_irq_stat & next_irq_en);
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = `HBMFC_RESP_OKAY;
            case (s_axi_araddr)
                `HBMFC_ADDR_STATE:
                begin
                    next_rdata = {20'h00000, sw, retry_short, prot, ot,
                        lockout, pwr, mode};
                end
                `HBMFC_ADDR_IRQ_STAT:
                begin
                    next_rdata = {26'h0000000, irq_stat};
                end
                `HBMFC_ADDR_IRQ_EN:
                begin
                    next_rdata = {26'h0000000, irq_en};
                end
                `HBMFC_ADDR_IRQ_CLR:
                begin
                    next_rdata = 32'h00000000;
                end
                default:
                begin
                    next_rdata = 32'h00000000;
                    next_rresp = `HBMFC_RESP_SLVERR;
                end
            endcase
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            irq_stat <= '0;
            irq_en <= `HBMFC_IRQ_EN_RST;
            irq <= 1'b0;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            irq <= next_irq;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_STANDBY_OFF: assert property ((mode == MD_STANDBY) |=> sw == '0)
        else $error("standby did not float the bridge");
    AST_FWD_MAP: assert property (enable && mode == MD_FORWARD |=>
        sw == 4'b1001 && out_a && out_a_oe && !out_b && out_b_oe)
        else $error("forward switch map wrong");
    AST_SLEEP_ENTRY: assert property (pwr == PW_ACTIVE &&
        mode == MD_STANDBY && pcnt == SLEEP_LIM |=> pwr == PW_SLEEP)
        else $error("sleep not entered after standby time");
    AST_SLEEP_FLOAT: assert property (pwr != PW_ACTIVE |-> sw == '0)
        else $error("switch on outside active period");
    AST_WAKE: assert property (pwr == PW_SLEEP && (in_a || in_b) |=>
        pwr == PW_WAKE ##1 pwr == PW_WAKE)
        else $error("wake not taken");
    AST_SLEEP_NOPROT: assert property (pwr == PW_SLEEP |=>
        prot == PR_RUN && $stable(lockout))
        else $error("protection acted during sleep");
    AST_CP_START: assert property (pwr == PW_WAKE && pcnt < CP_LIM |=>
        pwr == PW_WAKE)
        else $error("bridge enabled before charge pump time");
    AST_LOCKOUT: assert property (lockout |-> !out_a_oe && !out_b_oe)
        else $error("outputs driven under lockout");
    AST_UV_REENTER: assert property (pwr != PW_SLEEP && fl.uv_low |=>
        lockout)
        else $error("lockout not re-entered");
    AST_OC_DEG: assert property (prot == PR_RUN && driving && !lockout &&
        !fl.short_hit && fl.oc && dcnt == DEG_LIM |=>
        prot == PR_RETRY && sw == '0)
        else $error("over-current trip missing after deglitch");
    AST_RETRY_END: assert property (prot == PR_RETRY && rcnt == RETRY_LIM &&
        !retry_short && pwr != PW_SLEEP |=> prot == PR_RUN)
        else $error("retry did not release");
    AST_SHORT_FAST: assert property (prot == PR_RUN && driving && !lockout &&
        fl.short_hit |=> sw == '0 && prot == PR_RETRY)
        else $error("short did not act at once");
    AST_SHORT_HOLD: assert property (prot == PR_RETRY && retry_short &&
        rcnt == RETRY_LIM && fl.short_hit && pwr != PW_SLEEP |=>
        prot == PR_RETRY && rcnt == 20'h00000)
        else $error("short released while present");
    AST_OT_OFF: assert property (ot |-> sw == '0)
        else $error("switch on during over-temperature");
    AST_NO_RETRY_IDLE: assert property (prot == PR_RUN &&
        mode == MD_STANDBY |=> prot == PR_RUN)
        else $error("retry entered in standby");
    AST_IRQ_SET: assert property (ev != '0 |=> (irq_stat & $past(ev)) ==
        $past(ev))
        else $error("event lost in status");

endmodule // hbmfc_top

// ===== bench/hbmfc_host.sv
// ****************************************************************
// host controller model driving the two control pins
// ****************************************************************
module hbmfc_host (
    // clock
    input wire logic clk,
    // control pins toward the bridge
    output logic input_a,
    output logic input_b
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        input_a = 1'h0;
        input_b = 1'h0;
    end

    // pins change just after an edge, held as levels until next call
    task automatic drive(input logic a, input logic b);
        @(posedge clk);
        input_a <= a;
        input_b <= b;
    endtask
endmodule // hbmfc_host

// ===== bench/testbench.sv
module testbench;
    import hbmfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, sys_rst, input_a, input_b, irq;
    hbmfc_flags_t flags;
    hbmfc_sw_t sw;
    logic out_a, out_a_oe, out_b, out_b_oe;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int err_total = 0;
    int compares = 0;
    // {input_a, input_b, expected switches}
    logic [5:0] tt [4] = '{6'h29, 6'h16, 6'h35, 6'h00};

    hbmfc_host u_hbmfc_host (.clk, .input_a, .input_b);

    hbmfc_top #(.SLEEP_CYC(20), .CP_CYC(30), .RETRY_CYC(10)) u_hbmfc_top (
        .clk, .sys_rst, .input_a, .input_b, .flags, .sw, .out_a,
        .out_a_oe, .out_b, .out_b_oe, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // pin levels and enables follow from the expected switches
    task automatic chk_br(input logic [3:0] s);
        check({24'h0, sw, out_a, out_a_oe, out_b, out_b_oe},
            {24'h0, s, s[3], s[3] | s[2], s[1], s[1] | s[0]});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic fl(input logic [5:0] f);
        @(posedge clk);
        flags <= f;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        output logic [1:0] resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // ****************************************************************
    // clock, reset, watchdog
    // ****************************************************************
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        wt(20000);
        err_total++;
        report_and_stop();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        sys_rst = 1'h1;
        flags = 6'h11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        wt(3);
        sys_rst <= 1'h0;
        wt(6);
        chk_br(4'h0);
        rd(8'h0C, d, r);
        check(d, 32'h0);
        wr(8'h0C, 32'h3F, r);
        rd(8'h0C, d, r);
        check(d, 32'h3F);
        rd(8'h10, d, r);
        check({d[29:0], r}, 32'h2);
        wr(8'h10, 32'h0, r);
        check({30'h0, r}, 32'h2);
        wr(8'h00, 32'hFFF, r);
        check({30'h0, r}, 32'h0);
        // the register traffic above outlasts the standby time
        rd(8'h00, d, r);
        check({30'h0, d[3:2]}, 32'h1);
        u_hbmfc_host.drive(1'h1, 1'h0);
        wt(40);
        check({31'h0, irq}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            u_hbmfc_host.drive(tt[i][5], tt[i][4]);
            wt(8);
            chk_br(tt[i][3:0]);
        end
        u_hbmfc_host.drive(1'h1, 1'h0);
        wr(8'h08, 32'h3F, r);
        wt(3);
        check({31'h0, irq}, 32'h0);
        // over-current: survives the deglitch, then trips and retries
        fl(6'h19);
        wt(20);
        chk_br(4'h9);
        wt(15);
        chk_br(4'h0);
        check({31'h0, irq}, 32'h1);
        fl(6'h11);
        rd(8'h04, d, r);
        check(d & 32'h1, 32'h1);
        wt(20);
        chk_br(4'h9);
        wr(8'h0C, 32'h0, r);
        wt(3);
        check({31'h0, irq}, 32'h0);
        wr(8'h0C, 32'h3F, r);
        wt(3);
        check({31'h0, irq}, 32'h1);
        wr(8'h08, 32'h3F, r);
        wt(3);
        check({31'h0, irq}, 32'h0);
        // short: no deglitch, stays off across retries
        fl(6'h15);
        wt(5);
        chk_br(4'h0);
        wt(35);
        chk_br(4'h0);
        fl(6'h11);
        wt(20);
        chk_br(4'h9);
        rd(8'h04, d, r);
        check(d & 32'h2, 32'h2);
        // over-temperature releases only on the recovery flag
        fl(6'h12);
        wt(6);
        chk_br(4'h0);
        fl(6'h10);
        wt(10);
        chk_br(4'h0);
        fl(6'h11);
        wt(8);
        chk_br(4'h9);
        // lockout with hysteresis, inputs ignored meanwhile
        fl(6'h21);
        wt(6);
        chk_br(4'h0);
        fl(6'h01);
        u_hbmfc_host.drive(1'h0, 1'h1);
        wt(8);
        chk_br(4'h0);
        fl(6'h11);
        wt(8);
        chk_br(4'h6);
        // standby: over-temperature still latches, then sleep
        wr(8'h08, 32'h3F, r);
        u_hbmfc_host.drive(1'h0, 1'h0);
        fl(6'h12);
        wt(4);
        rd(8'h00, d, r);
        check({31'h0, d[5]}, 32'h1);
        fl(6'h11);
        wt(40);
        rd(8'h00, d, r);
        check({30'h0, d[3:2]}, 32'h1);
        fl(6'h1D);
        wt(10);
        chk_br(4'h0);
        fl(6'h11);
        rd(8'h04, d, r);
        check(d & 32'h3, 32'h0);
        u_hbmfc_host.drive(1'h1, 1'h0);
        wt(15);
        chk_br(4'h0);
        wt(30);
        chk_br(4'h9);
        rd(8'h00, d, r);
        check({30'h0, d[3:2]}, 32'h0);
        report_and_stop();
    end
endmodule // testbench
